// >>> pkg/mlac_pkg.sv
// Shared constants and types for the memory lock and access control block.
package mlac_pkg;
	// I/O space windows seen by the CPU.
	localparam logic [11:0] IO_SHORT_LAST = 12'h03F;
	localparam logic [11:0] IO_EXT_FIRST = 12'h040;
	localparam logic [11:0] IO_EXT_LAST = 12'hFFF;
	localparam logic [11:0] IO_BIT_LAST = 12'h01F;
	// General store base in I/O space and offsets inside the block.
	localparam logic [11:0] IO_GSTORE_BASE = 12'h01C;
	localparam logic [1:0] GSTORE0_OFFSET = 2'h0;
	localparam logic [1:0] GSTORE1_OFFSET = 2'h1;
	localparam logic [1:0] GSTORE2_OFFSET = 2'h2;
	localparam logic [1:0] GSTORE3_OFFSET = 2'h3;
	localparam logic [7:0] GSTORE_RESET = 8'h00;
	// Write-one-to-clear event flag register address in I/O space.
	localparam logic [11:0] IO_FLAGS_ADDR = 12'h01B;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// Signature address space: three bytes at 0x00 to 0x02.
	localparam logic [7:0] SIG_FIRST = 8'h00;
	localparam logic [7:0] SIG_LAST = 8'h02;
	// Lock fuse field: the single value that means unlocked.
	localparam logic [7:0] LOCK_UNLOCKED = 8'hC5;
	// Data returned by a debug read that is not allowed.
	localparam logic [7:0] DENY_DATA = 8'hFF;
	// Erased byte value of the data store; erase sets the lock fuse store to the unlock value instead.
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// Memory sections addressed by either party.
	typedef enum logic [2:0]
	{
		SEC_DATA_STORE = 3'h0,
		SEC_SETTINGS = 3'h1,
		SEC_SIGNATURE = 3'h2,
		SEC_FUSE = 3'h3,
		SEC_SYSINFO = 3'h4,
		SEC_EXTERNAL = 3'h5
	} mlac_section_type;
	// Single-bit instruction kinds on the CPU I/O path.
	typedef enum logic [2:0]
	{
		BIT_NONE = 3'h0,
		BIT_SET = 3'h1,
		BIT_CLEAR = 3'h2,
		BIT_SKIP_SET = 3'h3,
		BIT_SKIP_CLEAR = 3'h4
	} mlac_bitop_type;
endpackage

// >>> src/mlac_access_ctrl.sv
// Memory lock and access control: nonvolatile stores, I/O windows, general stores and debug gating.
`timescale 1ns/1ps
module mlac_access_ctrl
#(
	parameter int DATA_BYTES = 256,
	parameter int PAGE_BYTES = 32,
	parameter logic [7:0] SIG_BYTE0 = 8'hA1, // Arbitrary identification value.
	parameter logic [7:0] SIG_BYTE1 = 8'hB2, // Arbitrary identification value.
	parameter logic [7:0] SIG_BYTE2 = 8'hC3, // Arbitrary identification value.
	parameter logic [7:0] SYSINFO_BYTE = 8'h5A // Arbitrary system information value.
)
(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic fuse_load_i,
	input wire logic [11:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic io_long_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic [2:0] io_bitop_i,
	input wire logic [2:0] io_bit_i,
	input wire logic [7:0] flag_evt_i,
	output logic [7:0] io_rdata_o,
	output logic io_ack_o,
	output logic io_skip_o,
	output logic io_ext_rd_o,
	output logic io_ext_wr_o,
	input wire logic [2:0] cpu_sec_i,
	input wire logic [7:0] cpu_addr_i,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic [7:0] cpu_wdata_i,
	output logic [7:0] cpu_rdata_o,
	output logic cpu_ack_o,
	input wire logic [2:0] dbg_sec_i,
	input wire logic [7:0] dbg_addr_i,
	input wire logic dbg_rd_i,
	input wire logic dbg_wr_i,
	input wire logic [7:0] dbg_wdata_i,
	input wire logic dbg_erase_i,
	input wire logic [7:0] dbg_ext_rdata_i,
	output logic [7:0] dbg_rdata_o,
	output logic dbg_ack_o,
	output logic dbg_denied_o,
	output logic dbg_ext_rd_o,
	output logic dbg_ext_wr_o,
	output logic locked_o,
	output logic [7:0] gstore0_o
);
	localparam int DA_W = $clog2(DATA_BYTES);
	localparam int PA_W = $clog2(PAGE_BYTES);
	// Storage arrays; the data store and settings page arrays have no reset value.
	logic [7:0] data_mem [DATA_BYTES];
	logic [7:0] page_mem [PAGE_BYTES];
	logic [7:0] gstore_reg [4];
	logic [7:0] flags_reg;
	logic [7:0] fuse_store_reg;
	logic [7:0] lock_reg;
	logic [7:0] io_rdata_reg;
	logic io_ack_reg;
	logic io_skip_reg;
	logic io_ext_rd_reg;
	logic io_ext_wr_reg;
	logic [7:0] cpu_rdata_reg;
	logic cpu_ack_reg;
	logic [7:0] dbg_rdata_reg;
	logic dbg_ack_reg;
	logic dbg_denied_reg;
	logic dbg_ext_rd_reg;
	logic dbg_ext_wr_reg;
	logic locked_reg;

	// Signature byte lookup, shared by the CPU and debug read paths.
	function automatic logic [7:0] sig_byte(input logic [7:0] a);
		case (a)
			8'h00: return SIG_BYTE0;
			8'h01: return SIG_BYTE1;
			8'h02: return SIG_BYTE2;
			default: return 8'h00;
		endcase
	endfunction

	wire logic locked = (lock_reg != mlac_pkg::LOCK_UNLOCKED);
	// CPU I/O decode: short form reaches only 0x00-0x3F, long form both 0x00-0x3F and the extended range.
	wire logic io_req = io_rd_i | io_wr_i;
	wire logic io_in_short = (io_addr_i <= mlac_pkg::IO_SHORT_LAST);
	wire logic io_in_ext = (io_addr_i >= mlac_pkg::IO_EXT_FIRST) && (io_addr_i <= mlac_pkg::IO_EXT_LAST);
	wire logic io_short_ok = io_req && !io_long_i && io_in_short;
	wire logic io_ext_ok = io_req && io_long_i && io_in_ext;
	wire logic io_local_ok = io_short_ok || (io_req && io_long_i && io_in_short);
	wire logic bit_ok = (io_bitop_i != 3'(mlac_pkg::BIT_NONE)) && (io_addr_i <= mlac_pkg::IO_BIT_LAST);
	wire logic [7:0] bit_mask = 8'h01 << io_bit_i;
	wire logic gs_hit = (io_addr_i[11:2] == mlac_pkg::IO_GSTORE_BASE[11:2]);
	wire logic [1:0] gs_idx = io_addr_i[1:0];
	wire logic fl_hit = (io_addr_i == mlac_pkg::IO_FLAGS_ADDR);
	wire logic [7:0] io_cur = gs_hit ? gstore_reg[gs_idx] : (fl_hit ? flags_reg : 8'h00);
	wire logic is_set = (io_bitop_i == 3'(mlac_pkg::BIT_SET));
	wire logic is_clr = (io_bitop_i == 3'(mlac_pkg::BIT_CLEAR));
	wire logic is_tst = (io_bitop_i == 3'(mlac_pkg::BIT_SKIP_SET)) || (io_bitop_i == 3'(mlac_pkg::BIT_SKIP_CLEAR));
	wire logic tst_want = (io_bitop_i == 3'(mlac_pkg::BIT_SKIP_SET));
	wire logic bit_val = |(io_cur & bit_mask);
	wire logic gs_byte_wr = io_local_ok && io_wr_i && !bit_ok && gs_hit;
	wire logic gs_bit_wr = bit_ok && (is_set || is_clr) && gs_hit;
	wire logic [7:0] gs_bit_val = is_set ? (io_cur | bit_mask) : (io_cur & ~bit_mask);
	wire logic [7:0] fl_clear = (io_local_ok && io_wr_i && !bit_ok && fl_hit) ? io_wdata_i :
		((bit_ok && is_set && fl_hit) ? bit_mask : 8'h00);
	wire logic [7:0] flags_next = (flags_reg & ~fl_clear) | flag_evt_i;
	// CPU nonvolatile path; lock never restricts it.
	wire logic [DA_W-1:0] cpu_da = cpu_addr_i[DA_W-1:0];
	wire logic [PA_W-1:0] cpu_pa = cpu_addr_i[PA_W-1:0];
	wire logic cpu_req = cpu_rd_i | cpu_wr_i;
	wire logic cpu_wr_data = cpu_wr_i && (cpu_sec_i == 3'(mlac_pkg::SEC_DATA_STORE));
	wire logic cpu_wr_page = cpu_wr_i && (cpu_sec_i == 3'(mlac_pkg::SEC_SETTINGS));
	logic [7:0] cpu_rsel;
	// Debug path decode and permission.
	wire logic [DA_W-1:0] dbg_da = dbg_addr_i[DA_W-1:0];
	wire logic [PA_W-1:0] dbg_pa = dbg_addr_i[PA_W-1:0];
	wire logic dbg_req = dbg_rd_i | dbg_wr_i;
	wire logic dbg_is_data = (dbg_sec_i == 3'(mlac_pkg::SEC_DATA_STORE));
	wire logic dbg_is_page = (dbg_sec_i == 3'(mlac_pkg::SEC_SETTINGS));
	wire logic dbg_is_sig = (dbg_sec_i == 3'(mlac_pkg::SEC_SIGNATURE));
	wire logic dbg_is_fuse = (dbg_sec_i == 3'(mlac_pkg::SEC_FUSE));
	wire logic dbg_is_sib = (dbg_sec_i == 3'(mlac_pkg::SEC_SYSINFO));
	wire logic dbg_is_ext = (dbg_sec_i == 3'(mlac_pkg::SEC_EXTERNAL));
	wire logic dbg_rd_ok = dbg_rd_i && (dbg_is_sib || (!locked && !(dbg_is_sig && dbg_addr_i > mlac_pkg::SIG_LAST)));
	wire logic dbg_wr_ok = dbg_wr_i && (dbg_is_page || (!locked && (dbg_is_data || dbg_is_fuse || dbg_is_ext)));
	wire logic dbg_deny = (dbg_rd_i && !dbg_rd_ok) || (dbg_wr_i && !dbg_wr_ok);
	logic [7:0] dbg_rsel;

	// CPU read data selection; signature and fuses are readable, never writable.
	always_comb
	begin
		cpu_rsel = 8'h00;
		case (cpu_sec_i)
			3'(mlac_pkg::SEC_DATA_STORE): cpu_rsel = data_mem[cpu_da];
			3'(mlac_pkg::SEC_SETTINGS): cpu_rsel = page_mem[cpu_pa];
			3'(mlac_pkg::SEC_SIGNATURE): cpu_rsel = sig_byte(cpu_addr_i);
			3'(mlac_pkg::SEC_FUSE): cpu_rsel = fuse_store_reg;
			3'(mlac_pkg::SEC_SYSINFO): cpu_rsel = SYSINFO_BYTE;
			default: cpu_rsel = 8'h00;
		endcase
	end

	// Debug read data selection; a denied read still answers, with fixed filler.
	always_comb
	begin
		dbg_rsel = mlac_pkg::DENY_DATA;
		if (dbg_rd_ok)
		begin
			case (dbg_sec_i)
				3'(mlac_pkg::SEC_DATA_STORE): dbg_rsel = data_mem[dbg_da];
				3'(mlac_pkg::SEC_SETTINGS): dbg_rsel = page_mem[dbg_pa];
				3'(mlac_pkg::SEC_SIGNATURE): dbg_rsel = sig_byte(dbg_addr_i);
				3'(mlac_pkg::SEC_FUSE): dbg_rsel = fuse_store_reg;
				3'(mlac_pkg::SEC_SYSINFO): dbg_rsel = SYSINFO_BYTE;
				3'(mlac_pkg::SEC_EXTERNAL): dbg_rsel = dbg_ext_rdata_i;
				default: dbg_rsel = mlac_pkg::DENY_DATA;
			endcase
		end
	end

	// Data store writes; erase wins over a same-cycle byte write from either party.
	always_ff @(posedge sys_clk_i)
	begin
		if (dbg_erase_i)
		begin
			for (int i = 0; i < DATA_BYTES; i++)
				data_mem[i] <= mlac_pkg::ERASED_BYTE;
		end
		else if (dbg_wr_ok && dbg_is_data)
			data_mem[dbg_da] <= dbg_wdata_i;
		else if (cpu_wr_data)
			data_mem[cpu_da] <= cpu_wdata_i;
	end

	// Settings page writes; the erase deliberately leaves this array alone.
	always_ff @(posedge sys_clk_i)
	begin
		if (dbg_wr_ok && dbg_is_page)
			page_mem[dbg_pa] <= dbg_wdata_i;
		else if (cpu_wr_page)
			page_mem[cpu_pa] <= cpu_wdata_i;
	end

	// Stored lock fuse; only reset, erase or an unlocked debug write changes it.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			fuse_store_reg <= mlac_pkg::ERASED_BYTE;
		else if (dbg_erase_i)
			fuse_store_reg <= mlac_pkg::LOCK_UNLOCKED;
		else if (dbg_wr_ok && dbg_is_fuse)
			fuse_store_reg <= dbg_wdata_i;
	end

	// Active lock field; reset leaves the part locked until start-up loads the fuse.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			lock_reg <= mlac_pkg::ERASED_BYTE;
		else if (fuse_load_i)
			lock_reg <= fuse_store_reg;
	end

	// General stores take byte writes and single-bit writes.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			for (int i = 0; i < 4; i++)
				gstore_reg[i] <= mlac_pkg::GSTORE_RESET;
		end
		else if (gs_byte_wr)
			gstore_reg[gs_idx] <= io_wdata_i;
		else if (gs_bit_wr)
			gstore_reg[gs_idx] <= gs_bit_val;
	end

	// Event flags: a new event in the clearing cycle survives because set is applied last.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			flags_reg <= mlac_pkg::FLAGS_RESET;
		else
			flags_reg <= flags_next;
	end

	// CPU I/O answer, one cycle after the request; extended range is forwarded out.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			io_rdata_reg <= 8'h00;
			io_ack_reg <= 1'b0;
			io_skip_reg <= 1'b0;
			io_ext_rd_reg <= 1'b0;
			io_ext_wr_reg <= 1'b0;
		end
		else
		begin
			io_rdata_reg <= (io_local_ok && io_rd_i) ? io_cur : 8'h00;
			io_ack_reg <= io_local_ok || io_ext_ok || bit_ok;
			io_skip_reg <= bit_ok && is_tst && (bit_val == tst_want);
			io_ext_rd_reg <= io_ext_ok && io_rd_i;
			io_ext_wr_reg <= io_ext_ok && io_wr_i;
		end
	end

	// CPU nonvolatile answer and debug answer, both one cycle after the request.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cpu_rdata_reg <= 8'h00;
			cpu_ack_reg <= 1'b0;
			dbg_rdata_reg <= 8'h00;
			dbg_ack_reg <= 1'b0;
			dbg_denied_reg <= 1'b0;
			dbg_ext_rd_reg <= 1'b0;
			dbg_ext_wr_reg <= 1'b0;
			locked_reg <= 1'b1;
		end
		else
		begin
			cpu_rdata_reg <= cpu_rd_i ? cpu_rsel : 8'h00;
			cpu_ack_reg <= cpu_req;
			dbg_rdata_reg <= dbg_rd_i ? dbg_rsel : 8'h00;
			dbg_ack_reg <= dbg_req || dbg_erase_i;
			dbg_denied_reg <= dbg_req && dbg_deny;
			dbg_ext_rd_reg <= dbg_rd_ok && dbg_is_ext;
			dbg_ext_wr_reg <= dbg_wr_ok && dbg_is_ext;
			// The lock indication lags the active lock by a cycle so the port is registered.
			locked_reg <= locked;
		end
	end

	// Output mapping; every port follows a flop directly.
	assign io_rdata_o = io_rdata_reg;
	assign io_ack_o = io_ack_reg;
	assign io_skip_o = io_skip_reg;
	assign io_ext_rd_o = io_ext_rd_reg;
	assign io_ext_wr_o = io_ext_wr_reg;
	assign cpu_rdata_o = cpu_rdata_reg;
	assign cpu_ack_o = cpu_ack_reg;
	assign dbg_rdata_o = dbg_rdata_reg;
	assign dbg_ack_o = dbg_ack_reg;
	assign dbg_denied_o = dbg_denied_reg;
	assign dbg_ext_rd_o = dbg_ext_rd_reg;
	assign dbg_ext_wr_o = dbg_ext_wr_reg;
	assign locked_o = locked_reg;
	assign gstore0_o = gstore_reg[mlac_pkg::GSTORE0_OFFSET];
endmodule

// >>> testbench/mlac_access_ctrl_chk.sv
// Port checker for the memory lock and access control block.
`timescale 1ns/1ps
module mlac_access_ctrl_chk
(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic fuse_load_i,
	input wire logic [11:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic io_long_i,
	input wire logic [2:0] io_bitop_i,
	input wire logic io_ack_o,
	input wire logic io_skip_o,
	input wire logic io_ext_rd_o,
	input wire logic cpu_rd_i,
	input wire logic cpu_wr_i,
	input wire logic cpu_ack_o,
	input wire logic [2:0] dbg_sec_i,
	input wire logic dbg_rd_i,
	input wire logic dbg_wr_i,
	input wire logic dbg_erase_i,
	input wire logic [7:0] dbg_rdata_o,
	input wire logic dbg_ack_o,
	input wire logic dbg_denied_o,
	input wire logic dbg_ext_rd_o,
	input wire logic dbg_ext_wr_o,
	input wire logic locked_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic load_q;
	logic lock_steady;
	// The visible lock lags the active one by a cycle after a reload, so gating checks skip that gap.
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
		if (!rst_b_i)
			load_q <= 1'b0;
		else
			load_q <= fuse_load_i;
	assign lock_steady = locked_o && !fuse_load_i && !load_q;
	a_io_short_ack: assert property ((io_rd_i || io_wr_i) && !io_long_i && io_addr_i <= mlac_pkg::IO_SHORT_LAST |=> io_ack_o)
		else $error("short port access not answered next cycle");
	a_io_short_refuse: assert property ((io_rd_i || io_wr_i) && !io_long_i && io_addr_i > mlac_pkg::IO_SHORT_LAST
		|=> !io_ack_o && !io_ext_rd_o) else $error("short form reached extended range");
	a_io_ext_fwd: assert property (io_rd_i && io_long_i && io_addr_i >= mlac_pkg::IO_EXT_FIRST |=> io_ext_rd_o)
		else $error("extended load not forwarded");
	a_bit_high_refuse: assert property (io_bitop_i != 3'h0 && !io_rd_i && !io_wr_i && io_addr_i > mlac_pkg::IO_BIT_LAST
		|=> !io_ack_o && !io_skip_o) else $error("bit instruction taken above bit range");
	a_cpu_always_ack: assert property (cpu_rd_i || cpu_wr_i |=> cpu_ack_o)
		else $error("CPU access not answered");
	a_dbg_always_ack: assert property (dbg_rd_i || dbg_wr_i || dbg_erase_i |=> dbg_ack_o)
		else $error("debug access not completed");
	a_lock_read_deny: assert property (lock_steady && dbg_rd_i && dbg_sec_i != mlac_pkg::SEC_SYSINFO
		|=> dbg_denied_o && dbg_rdata_o == mlac_pkg::DENY_DATA) else $error("locked debug read not denied");
	a_lock_ext_gate: assert property (lock_steady && (dbg_rd_i || dbg_wr_i) && dbg_sec_i == mlac_pkg::SEC_EXTERNAL
		|=> !dbg_ext_rd_o && !dbg_ext_wr_o) else $error("locked debug access forwarded");
	a_settings_wr_open: assert property (dbg_wr_i && !dbg_erase_i && dbg_sec_i == mlac_pkg::SEC_SETTINGS
		|=> dbg_ack_o && !dbg_denied_o) else $error("settings page write denied");
	a_sig_wr_deny: assert property (dbg_wr_i && dbg_sec_i == mlac_pkg::SEC_SIGNATURE |=> dbg_denied_o)
		else $error("signature write not denied");
	a_sysinfo_open: assert property (dbg_rd_i && dbg_sec_i == mlac_pkg::SEC_SYSINFO |=> !dbg_denied_o)
		else $error("system info read denied");
	a_unlock_by_load: assert property ($fell(locked_o) |-> $past(fuse_load_i, 2))
		else $error("lock left without fuse reload");
endmodule
bind mlac_access_ctrl mlac_access_ctrl_chk u_chk (.sys_clk_i, .rst_b_i, .fuse_load_i, .io_addr_i, .io_rd_i, .io_wr_i,
	.io_long_i, .io_bitop_i, .io_ack_o, .io_skip_o, .io_ext_rd_o, .cpu_rd_i, .cpu_wr_i, .cpu_ack_o, .dbg_sec_i,
	.dbg_rd_i, .dbg_wr_i, .dbg_erase_i, .dbg_rdata_o, .dbg_ack_o, .dbg_denied_o, .dbg_ext_rd_o, .dbg_ext_wr_o, .locked_o);

// >>> testbench/mlac_access_ctrl_tb_top.sv
// Self-checking bench for the memory lock and access control block.
`timescale 1ns/1ps
module mlac_access_ctrl_tb_top;
	logic sys_clk_i = 1'b0, rst_b_i = 1'b0, fuse_load_i = 1'b0, io_rd_i = 1'b0, io_wr_i = 1'b0, io_long_i = 1'b0;
	logic cpu_rd_i = 1'b0, cpu_wr_i = 1'b0, dbg_rd_i = 1'b0, dbg_wr_i = 1'b0, dbg_erase_i = 1'b0;
	logic [11:0] io_addr_i = 12'h000;
	logic [7:0] io_wdata_i = 8'h00, flag_evt_i = 8'h00, cpu_addr_i = 8'h00, cpu_wdata_i = 8'h00;
	logic [7:0] dbg_addr_i = 8'h00, dbg_wdata_i = 8'h00;
	logic [2:0] io_bitop_i = 3'h0, io_bit_i = 3'h0, cpu_sec_i = 3'h0, dbg_sec_i = 3'h0;
	logic [7:0] dbg_ext_rdata_i, io_rdata_o, cpu_rdata_o, dbg_rdata_o, gstore0_o;
	logic io_ack_o, io_skip_o, io_ext_rd_o, io_ext_wr_o, cpu_ack_o, dbg_ack_o, dbg_denied_o, dbg_ext_rd_o, dbg_ext_wr_o;
	logic locked_o;
	int miscompares = 0;
	int n_compared = 0;
	// Signature and system info bytes are arbitrary values.
	mlac_access_ctrl #(.DATA_BYTES(128), .SIG_BYTE0(8'h11), .SIG_BYTE1(8'h22), .SIG_BYTE2(8'h33), .SYSINFO_BYTE(8'h44))
	dut (.sys_clk_i, .rst_b_i, .fuse_load_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_long_i, .io_wdata_i, .io_bitop_i,
		.io_bit_i, .flag_evt_i, .io_rdata_o, .io_ack_o, .io_skip_o, .io_ext_rd_o, .io_ext_wr_o, .cpu_sec_i, .cpu_addr_i,
		.cpu_rd_i, .cpu_wr_i, .cpu_wdata_i, .cpu_rdata_o, .cpu_ack_o, .dbg_sec_i, .dbg_addr_i, .dbg_rd_i, .dbg_wr_i,
		.dbg_wdata_i, .dbg_erase_i, .dbg_ext_rdata_i, .dbg_rdata_o, .dbg_ack_o, .dbg_denied_o, .dbg_ext_rd_o,
		.dbg_ext_wr_o, .locked_o, .gstore0_o);
	mlac_ext_mem u_ext (.sec_i(dbg_sec_i), .addr_i(dbg_addr_i), .rdata_o(dbg_ext_rdata_i));
	// Clock at 100 MHz.
	always #5 sys_clk_i = ~sys_clk_i;
	// Compares one value and counts it.
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task report_and_stop;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// no reserved writes
	// One I/O request held for one edge; a zero strobe pair with an op is a bit instruction.
	task io(input logic [1:0] wr_rd, input logic lg, input logic [11:0] a, input logic [7:0] d, input logic [2:0] op,
		input logic [2:0] b);
		@(posedge sys_clk_i);
		#1;
		{io_long_i, io_addr_i, io_wdata_i, io_bitop_i, io_bit_i} = {lg, a, d, op, b};
		{io_wr_i, io_rd_i} = wr_rd;
		@(posedge sys_clk_i);
		#1;
		{io_wr_i, io_rd_i} = 2'b00;
		io_bitop_i = 3'h0;
	endtask
	// One CPU section access; outputs of the transfer stand when it returns.
	task cpu(input logic [2:0] s, input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		{cpu_sec_i, cpu_addr_i, cpu_wdata_i} = {s, a, d};
		{cpu_wr_i, cpu_rd_i} = {w, !w};
		@(posedge sys_clk_i);
		#1;
		{cpu_wr_i, cpu_rd_i} = 2'b00;
	endtask
	// One debug access; ewr holds erase, write and read strobes.
	task dbg(input logic [2:0] s, input logic [7:0] a, input logic [2:0] ewr, input logic [7:0] d);
		@(posedge sys_clk_i);
		#1;
		{dbg_sec_i, dbg_addr_i, dbg_wdata_i} = {s, a, d};
		{dbg_erase_i, dbg_wr_i, dbg_rd_i} = ewr;
		@(posedge sys_clk_i);
		#1;
		{dbg_erase_i, dbg_wr_i, dbg_rd_i} = 3'b000;
	endtask
	// Pulses the start-up load and waits until the lock indication has followed it.
	task reload_fuse;
		@(posedge sys_clk_i);
		#1;
		fuse_load_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		fuse_load_i = 1'b0;
		@(posedge sys_clk_i);
		#1;
	endtask
	// Main sequence: registers, bit instructions, flags, CPU sections, then the locked and unlocked debug port.
	initial
	begin
		repeat (12) @(posedge sys_clk_i);
		#1;
		rst_b_i = 1'b1;
		chk(8'(locked_o), 8'h01);
		chk(gstore0_o, mlac_pkg::GSTORE_RESET);
		for (int i = 0; i < 4; i++)
		begin
			io(2'b01, 1'b0, mlac_pkg::IO_GSTORE_BASE + 12'(i), 8'h00, 3'h0, 3'h0);
			chk(io_rdata_o, mlac_pkg::GSTORE_RESET);
			io(2'b10, 1'b0, mlac_pkg::IO_GSTORE_BASE + 12'(i), 8'h5A ^ 8'(i), 3'h0, 3'h0);
			chk(8'(io_ack_o), 8'h01);
			io(2'b01, 1'b1, mlac_pkg::IO_GSTORE_BASE + 12'(i), 8'h00, 3'h0, 3'h0);
			chk(io_rdata_o, 8'h5A ^ 8'(i));
		end
		io(2'b00, 1'b0, mlac_pkg::IO_GSTORE_BASE, 8'h00, mlac_pkg::BIT_SET, 3'h0);
		chk(gstore0_o, 8'h5B);
		io(2'b00, 1'b0, mlac_pkg::IO_GSTORE_BASE, 8'h00, mlac_pkg::BIT_CLEAR, 3'h3);
		chk(gstore0_o, 8'h53);
		io(2'b00, 1'b0, mlac_pkg::IO_GSTORE_BASE, 8'h00, mlac_pkg::BIT_SKIP_SET, 3'h6);
		chk(8'(io_skip_o), 8'h01);
		io(2'b00, 1'b0, mlac_pkg::IO_GSTORE_BASE, 8'h00, mlac_pkg::BIT_SKIP_SET, 3'h7);
		chk(8'(io_skip_o), 8'h00);
		io(2'b00, 1'b0, mlac_pkg::IO_GSTORE_BASE, 8'h00, mlac_pkg::BIT_SKIP_CLEAR, 3'h7);
		chk(8'(io_skip_o), 8'h01);
		io(2'b00, 1'b0, 12'h020, 8'h00, mlac_pkg::BIT_SET, 3'h0);
		chk(8'(io_ack_o), 8'h00);
		io(2'b01, 1'b0, 12'h040, 8'h00, 3'h0, 3'h0);
		chk(8'({io_ack_o, io_ext_rd_o}), 8'h00);
		io(2'b01, 1'b1, 12'h040, 8'h00, 3'h0, 3'h0);
		chk(8'(io_ext_rd_o), 8'h01);
		io(2'b10, 1'b1, 12'hFFF, 8'h00, 3'h0, 3'h0);
		chk(8'(io_ext_wr_o), 8'h01);
		@(posedge sys_clk_i);
		#1;
		flag_evt_i = 8'hFF;
		@(posedge sys_clk_i);
		#1;
		flag_evt_i = 8'h00;
		io(2'b10, 1'b0, mlac_pkg::IO_FLAGS_ADDR, 8'h01, 3'h0, 3'h0);
		io(2'b00, 1'b0, mlac_pkg::IO_FLAGS_ADDR, 8'h00, mlac_pkg::BIT_SET, 3'h3);
		io(2'b01, 1'b0, mlac_pkg::IO_FLAGS_ADDR, 8'h00, 3'h0, 3'h0);
		chk(io_rdata_o, 8'hF6);
		cpu(mlac_pkg::SEC_DATA_STORE, 8'h7F, 1'b1, 8'h12);
		chk(8'(cpu_ack_o), 8'h01);
		cpu(mlac_pkg::SEC_DATA_STORE, 8'h7F, 1'b0, 8'h00);
		chk(cpu_rdata_o, 8'h12);
		cpu(mlac_pkg::SEC_SETTINGS, 8'h1F, 1'b1, 8'h34);
		cpu(mlac_pkg::SEC_SETTINGS, 8'h1F, 1'b0, 8'h00);
		chk(cpu_rdata_o, 8'h34);
		cpu(mlac_pkg::SEC_SIGNATURE, 8'h01, 1'b1, 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			cpu(mlac_pkg::SEC_SIGNATURE, 8'(i), 1'b0, 8'h00);
			chk(cpu_rdata_o, 8'h11 * 8'(i + 1));
		end
		dbg(mlac_pkg::SEC_DATA_STORE, 8'h7F, 3'b001, 8'h00);
		chk(8'({dbg_ack_o, dbg_denied_o}), 8'h03);
		chk(dbg_rdata_o, mlac_pkg::DENY_DATA);
		dbg(mlac_pkg::SEC_SYSINFO, 8'h00, 3'b001, 8'h00);
		chk(8'(dbg_denied_o), 8'h00);
		chk(dbg_rdata_o, 8'h44);
		dbg(mlac_pkg::SEC_SETTINGS, 8'h02, 3'b010, 8'h9C);
		chk(8'({dbg_ack_o, dbg_denied_o}), 8'h02);
		dbg(mlac_pkg::SEC_SETTINGS, 8'h02, 3'b001, 8'h00);
		chk(dbg_rdata_o, mlac_pkg::DENY_DATA);
		cpu(mlac_pkg::SEC_SETTINGS, 8'h02, 1'b0, 8'h00);
		chk(cpu_rdata_o, 8'h9C);
		dbg(mlac_pkg::SEC_EXTERNAL, 8'h10, 3'b001, 8'h00);
		chk(8'(dbg_ext_rd_o), 8'h00);
		dbg(mlac_pkg::SEC_DATA_STORE, 8'h00, 3'b100, 8'h00);
		chk(8'(locked_o), 8'h01);
		reload_fuse();
		chk(8'(locked_o), 8'h00);
		cpu(mlac_pkg::SEC_DATA_STORE, 8'h7F, 1'b0, 8'h00);
		chk(cpu_rdata_o, mlac_pkg::ERASED_BYTE);
		cpu(mlac_pkg::SEC_SETTINGS, 8'h02, 1'b0, 8'h00);
		chk(cpu_rdata_o, 8'h9C);
		dbg(mlac_pkg::SEC_SIGNATURE, 8'h02, 3'b001, 8'h00);
		chk(dbg_rdata_o, 8'h33);
		dbg(mlac_pkg::SEC_SIGNATURE, 8'h00, 3'b010, 8'h00);
		chk(8'(dbg_denied_o), 8'h01);
		dbg(mlac_pkg::SEC_SETTINGS, 8'h02, 3'b001, 8'h00);
		chk(dbg_rdata_o, 8'h9C);
		dbg(mlac_pkg::SEC_EXTERNAL, 8'h10, 3'b001, 8'h00);
		chk(8'(dbg_ext_rd_o), 8'h01);
		chk(dbg_rdata_o, 8'hB5);
		dbg(mlac_pkg::SEC_EXTERNAL, 8'h10, 3'b010, 8'h00);
		chk(8'(dbg_ext_wr_o), 8'h01);
		// Any stored fuse value but the unlock code relocks, and only once it is loaded.
		dbg(mlac_pkg::SEC_FUSE, 8'h00, 3'b010, 8'hC4);
		chk(8'(dbg_denied_o), 8'h00);
		chk(8'(locked_o), 8'h00);
		reload_fuse();
		chk(8'(locked_o), 8'h01);
		dbg(mlac_pkg::SEC_DATA_STORE, 8'h7F, 3'b001, 8'h00);
		chk(dbg_rdata_o, mlac_pkg::DENY_DATA);
		report_and_stop();
	end
	// Watchdog well beyond the roughly 120 cycles the sequence needs.
	initial
	begin
		#50000;
		miscompares++;
		report_and_stop();
	end
endmodule

// >>> testbench/mlac_ext_mem.sv
// Far-side model of the working memory, register and program sections reached by the debug port.
`timescale 1ns/1ps
module mlac_ext_mem
(
	input wire logic [2:0] sec_i,
	input wire logic [7:0] addr_i,
	output logic [7:0] rdata_o
);
	// Answers in the same cycle; off its own section it shows the inverse, so stale data never passes as a match.
	assign rdata_o = (sec_i == mlac_pkg::SEC_EXTERNAL) ? (addr_i ^ 8'hA5) : ~(addr_i ^ 8'hA5);
endmodule
